// file: shared/out_route_pkg.sv
// constants, register map and timing for the output routing block
// Function
// - routing mode is active only while the routing-enable control bit holds 1.
// - while routing is active the polarity, manual-enable and manual-value masks are ignored.
// - five routing entries exist, entry 0 for the software PWM output, entries 1-4 for outputs 1-4.
// - each entry is 16 bits, upper byte picks the source, lower byte picks the gating bit.
// - entry bit 7 clear means gating bit 1 enables the signal, set means gating bit 0 enables it.
// - source 0x00 drives a constant 1 and source 0x01 a constant 0.
// - sources 0x02-0x08 give encoder change pulses divided by 1, 2, 4, 8, 16, 32 and 64.
// - sources 0x09-0x0F give position change pulses divided by 1, 2, 4, 8, 16, 32 and 64.
// - with divider 1 every single-increment change of the count yields one output pulse.
// - encoder sources produce pulses only with encoder feedback, never with Hall sensors.
// - pulse sources are limited to 2 kHz on the PWM output and to 500 Hz on all other outputs.
// - entry value 0x0405 routes the encoder divided by 4, enabled by control word bit 5.
package out_route_pkg;
  localparam int NUM_ROUTES = 5;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int ROUTE_W    = 16;

  localparam logic [7:0] ROUTE0_OFS  = 8'h00;
  localparam logic [7:0] CTRL_OFS    = 8'h14;
  localparam logic [7:0] POL_OFS     = 8'h18;
  localparam logic [7:0] MAN_EN_OFS  = 8'h1C;
  localparam logic [7:0] MAN_VAL_OFS = 8'h20;
  localparam logic [7:0] OCW_OFS     = 8'h24;
  localparam logic [7:0] STATUS_OFS  = 8'h28;

  localparam logic [15:0] ROUTE_RESET = 16'h0100;
  localparam logic [31:0] MASK_RESET  = 32'h00000000;
  localparam logic [31:0] OCW_RESET   = 32'h00000000;

  localparam int CTRL_EN_BIT      = 0;
  localparam int STAT_ROUTING_BIT = 8;
  localparam int STAT_HALL_BIT    = 9;
  localparam int SRC_HI           = 15;
  localparam int SRC_LO           = 8;
  localparam int INV_BIT          = 7;
  localparam int IDX_HI           = 6;
  localparam int OUT_BIT_BASE     = 16;

  localparam logic [7:0] SRC_ONE       = 8'h00;
  localparam logic [7:0] SRC_ZERO      = 8'h01;
  localparam logic [7:0] SRC_ENC_FIRST = 8'h02;
  localparam logic [7:0] SRC_ENC_LAST  = 8'h08;
  localparam logic [7:0] SRC_POS_FIRST = 8'h09;
  localparam logic [7:0] SRC_POS_LAST  = 8'h0F;

  localparam int CLK_PERIOD_NS     = 5;
  localparam int PWM_MIN_PERIOD_NS = 500000;
  localparam int OUT_MIN_PERIOD_NS = 2000000;
  localparam int PWM_HALF_CYC = (PWM_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int OUT_HALF_CYC = (OUT_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

  localparam int DIV_SEL_W   = 3;
  localparam int DIV_CNT_W   = 6;
  localparam int PEND_W      = 8;
  localparam int SHAPE_CNT_W = 18;
endpackage

// file: design/change_divider.sv
// divides a stream of change events by a power of two
`timescale 1ns/1ps
module change_divider #(
  parameter int CNT_W = out_route_pkg::DIV_CNT_W
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  input  wire logic                            clear,
  input  wire logic                            event_in,
  input  wire logic [out_route_pkg::DIV_SEL_W-1:0] div_sel,
  output logic                                 strobe
);
  import out_route_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             strobe;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [CNT_W-1:0] mask;

  always_comb begin
    mask = CNT_W'((1 << div_sel) - 1);
    next_st = st;
    next_st.strobe = 1'b0;
    if (clear) begin
      next_st.cnt = '0;
    end else if (event_in) begin
      next_st.cnt = st.cnt + 1'b1;
      next_st.strobe = ((st.cnt & mask) == mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign strobe = st.strobe;

  AST_DIV_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.strobe) |-> $past(event_in) && ($past(st.cnt & mask) == $past(mask)))
    else $error("divider strobe without completed count");
endmodule

// file: design/pulse_shaper.sv
// turns strobes into pulses with a minimum high and low time
`timescale 1ns/1ps
module pulse_shaper #(
  parameter int HALF_CYC = out_route_pkg::OUT_HALF_CYC,
  parameter int CNT_W    = out_route_pkg::SHAPE_CNT_W,
  parameter int PEND_W   = out_route_pkg::PEND_W
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic strobe,
  output logic      level
);
  import out_route_pkg::*;

  typedef struct packed {
    logic [PEND_W-1:0] pend;
    logic [CNT_W-1:0]  cnt;
    logic              level;
  } shape_state_t;

  shape_state_t st;
  shape_state_t next_st;
  logic [PEND_W-1:0] pend_in;

  // backlog saturates: a burst faster than the rate limit is stretched, excess is dropped
  always_comb begin
    next_st = st;
    pend_in = (strobe && st.pend != '1) ? st.pend + 1'b1 : st.pend;
    next_st.pend = pend_in;
    if (clear) begin
      next_st = '0;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end else if (st.level) begin
      next_st.level = 1'b0;
      next_st.cnt = CNT_W'(HALF_CYC - 1);
    end else if (pend_in != '0) begin
      next_st.level = 1'b1;
      next_st.cnt = CNT_W'(HALF_CYC - 1);
      next_st.pend = pend_in - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign level = st.level;

  AST_RATE_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.level) |-> $past(st.cnt) == '0)
    else $error("pulse started before low time expired");
  AST_RATE_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.level) && !$past(clear) |-> $past(st.cnt) == '0)
    else $error("pulse ended before high time expired");
endmodule

// file: design/output_signal_routing.sv
// output routing top: APB registers, source selection, gating and legacy output path
`timescale 1ns/1ps
module output_signal_routing #(
  parameter int PWM_HALF = out_route_pkg::PWM_HALF_CYC,
  parameter int OUT_HALF = out_route_pkg::OUT_HALF_CYC
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [out_route_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [out_route_pkg::DATA_W-1:0]  pwdata,
  output logic      [out_route_pkg::DATA_W-1:0]  prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              hall_sel,
  input  wire logic [31:0]                       enc_count,
  input  wire logic [31:0]                       pos_actual,
  output logic                                   pwm_out,
  output logic      [3:0]                        dout
);
  import out_route_pkg::*;

  typedef struct packed {
    logic [NUM_ROUTES-1:0][ROUTE_W-1:0] route;
    logic                               route_en;
    logic [31:0]                        pol;
    logic [31:0]                        man_en;
    logic [31:0]                        man_val;
    logic [31:0]                        ocw;
    logic [31:0]                        prev_enc;
    logic [31:0]                        prev_pos;
    logic                               hall_s1;
    logic                               hall_s2;
    logic [NUM_ROUTES-1:0]              outs;
    logic [DATA_W-1:0]                  prdata;
    logic                               pready;
    logic                               pslverr;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic                 wr_en;
  logic                 hit;
  logic [DATA_W-1:0]    rdata;
  logic                 enc_chg;
  logic                 pos_chg;
  logic [NUM_ROUTES-1:0] route_wr;
  logic [NUM_ROUTES-1:0] clr;
  logic [NUM_ROUTES-1:0] evt;
  logic [NUM_ROUTES-1:0] strobe;
  logic [NUM_ROUTES-1:0] shaped;
  logic [NUM_ROUTES-1:0] active;
  logic [NUM_ROUTES-1:0] routed;
  logic [NUM_ROUTES-1:0] legacy;
  logic [NUM_ROUTES-1:0] is_enc;
  logic [NUM_ROUTES-1:0] is_pos;
  logic [NUM_ROUTES-1:0][DIV_SEL_W-1:0] div_sel;

  // a write lands only in the access cycle, after the setup cycle raised pready
  assign wr_en = psel && penable && pwrite && st.pready && !st.pslverr;
  // any change of the count is one increment step; faster multi-step jumps count once
  assign enc_chg = (enc_count != st.prev_enc) && !st.hall_s2;
  assign pos_chg = pos_actual != st.prev_pos;

  // read decode
  always_comb begin
    hit = 1'b1;
    rdata = '0;
    case (paddr)
      CTRL_OFS:    rdata[CTRL_EN_BIT] = st.route_en;
      POL_OFS:     rdata = st.pol;
      MAN_EN_OFS:  rdata = st.man_en;
      MAN_VAL_OFS: rdata = st.man_val;
      OCW_OFS:     rdata = st.ocw;
      STATUS_OFS: begin
        rdata[NUM_ROUTES-1:0] = st.outs;
        rdata[STAT_ROUTING_BIT] = st.route_en;
        rdata[STAT_HALL_BIT] = st.hall_s2;
      end
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_ROUTES; i++) begin
      if (paddr == ADDR_W'(ROUTE0_OFS + 4 * i)) begin
        hit = 1'b1;
        rdata = {16'h0000, st.route[i]};
      end
    end
  end

  // per-entry source selection and gating
  always_comb begin
    for (int i = 0; i < NUM_ROUTES; i++) begin
      logic [7:0] src;
      logic [6:0] idx;
      logic       gate;
      src = st.route[i][SRC_HI:SRC_LO];
      idx = st.route[i][IDX_HI:0];
      gate = (idx < 7'd32) ? st.ocw[idx[4:0]] : 1'b0;
      active[i] = gate ^ st.route[i][INV_BIT];
      is_enc[i] = (src >= SRC_ENC_FIRST) && (src <= SRC_ENC_LAST);
      is_pos[i] = (src >= SRC_POS_FIRST) && (src <= SRC_POS_LAST);
      div_sel[i] = is_enc[i] ? DIV_SEL_W'(src - SRC_ENC_FIRST)
                             : DIV_SEL_W'(src - SRC_POS_FIRST);
      evt[i] = (is_enc[i] && enc_chg) || (is_pos[i] && pos_chg);
      route_wr[i] = wr_en && (paddr == ADDR_W'(ROUTE0_OFS + 4 * i));
      clr[i] = route_wr[i] || !st.route_en;
      case (src)
        SRC_ONE:  routed[i] = 1'b1;
        SRC_ZERO: routed[i] = 1'b0;
        default:  routed[i] = (is_enc[i] && !st.hall_s2) || is_pos[i] ? shaped[i] : 1'b0;
      endcase
      // the PWM entry has no legacy path and idles low outside routing
      if (i == 0) begin
        legacy[i] = 1'b0;
      end else if (st.man_en[OUT_BIT_BASE + i - 1]) begin
        legacy[i] = st.man_val[OUT_BIT_BASE + i - 1];
      end else begin
        legacy[i] = st.ocw[OUT_BIT_BASE + i - 1] ^ st.pol[OUT_BIT_BASE + i - 1];
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.hall_s1 = hall_sel;
    next_st.hall_s2 = st.hall_s1;
    next_st.prev_enc = enc_count;
    next_st.prev_pos = pos_actual;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit || (pwrite && paddr == STATUS_OFS);
      next_st.prdata = (pwrite || !hit) ? '0 : rdata;
    end
    if (wr_en) begin
      case (paddr)
        CTRL_OFS:    next_st.route_en = pwdata[CTRL_EN_BIT];
        POL_OFS:     next_st.pol = pwdata;
        MAN_EN_OFS:  next_st.man_en = pwdata;
        MAN_VAL_OFS: next_st.man_val = pwdata;
        OCW_OFS:     next_st.ocw = pwdata;
        default: ;
      endcase
      for (int i = 0; i < NUM_ROUTES; i++) begin
        if (route_wr[i]) begin
          next_st.route[i] = pwdata[ROUTE_W-1:0];
        end
      end
    end
    for (int i = 0; i < NUM_ROUTES; i++) begin
      // routing overrides the masks entirely, inactive gate forces low
      next_st.outs[i] = st.route_en ? (active[i] && routed[i]) : legacy[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.route <= {NUM_ROUTES{ROUTE_RESET}};
      st.pol <= MASK_RESET;
      st.man_en <= MASK_RESET;
      st.man_val <= MASK_RESET;
      st.ocw <= OCW_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ROUTES; g++) begin : gen_route
      change_divider u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .clear    (clr[g]),
        .event_in (evt[g]),
        .div_sel  (div_sel[g]),
        .strobe   (strobe[g])
      );
      pulse_shaper #(
        .HALF_CYC (g == 0 ? PWM_HALF : OUT_HALF)
      ) u_shape (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .clear   (clr[g]),
        .strobe  (strobe[g]),
        .level   (shaped[g])
      );
    end
  endgenerate

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pwm_out = st.outs[0];
  assign dout = st.outs[NUM_ROUTES-1:1];

  AST_LEGACY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !st.route_en |=> {dout, pwm_out} == $past(legacy))
    else $error("legacy path not followed while routing off");
  AST_MASKS_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st.route_en && !active[1] |=> !dout[0])
    else $error("output 1 driven while its gate is inactive");
  AST_CONST_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st.route_en && active[0] && st.route[0][SRC_HI:SRC_LO] == SRC_ONE |=> pwm_out)
    else $error("constant one source not driven");
  AST_CONST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st.route_en && st.route[2][SRC_HI:SRC_LO] == SRC_ZERO |=> !dout[1])
    else $error("constant zero source not driven");
  AST_GATE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st.route_en && !active[4] |=> !dout[3])
    else $error("inactive gate left output high");
  AST_HALL_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st.route_en && st.hall_s2 && is_enc[1] |=> !dout[0])
    else $error("encoder pulses emitted with hall feedback");
  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable |=> pready ##1 (!pready || !ce))
    else $error("apb ready not exactly one access cycle");
  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable && !hit |=> pslverr && prdata == '0)
    else $error("unmapped access not flagged");

  COV_ROUTE_ON: cover property (@(posedge pclk) disable iff (!presetn) $rose(st.route_en));
  COV_ENC_PULSE: cover property (@(posedge pclk) disable iff (!presetn)
    st.route_en && is_enc[1] && $rose(dout[0]));
  COV_POS_PULSE: cover property (@(posedge pclk) disable iff (!presetn)
    st.route_en && is_pos[0] && $rose(pwm_out));
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// file: tb/out_load_model.sv
// loads on the routed output pins: counts pulses and measures high times
`timescale 1ns/1ps
module out_load_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       measure,
  input  wire logic       pwm_out,
  input  wire logic [3:0] dout,
  output int              edges [5],
  output int              min_hi [5]
);
  logic [4:0] lines;
  logic [4:0] prev;
  int         run [5];

  assign lines = {dout, pwm_out};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        edges[i]  <= 0;
        run[i]    <= 0;
        min_hi[i] <= 32'h7FFFFFFF;
      end
    end else begin
      prev <= lines;
      for (int i = 0; i < 5; i++) begin
        if (lines[i] && !prev[i])
          edges[i] <= edges[i] + 1;
        run[i] <= lines[i] ? run[i] + 1 : 0;
        // only pulse runs count, constant levels may be short between writes
        if (!lines[i] && prev[i] && measure && run[i] < min_hi[i])
          min_hi[i] <= run[i];
      end
    end
  end
endmodule

// file: tb/output_signal_routing_tb.sv
// self-checking bench for the output routing block
`timescale 1ns/1ps
module output_signal_routing_tb;
  import out_route_pkg::*;
  localparam int PH = 4;
  localparam int OH = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hall_sel = 1'b0;
  logic [31:0] enc_count = 32'h0;
  logic [31:0] pos_actual = 32'h0;
  logic        pwm_out;
  logic [3:0]  dout;
  logic        measure = 1'b0;
  int          edges [5];
  int          min_hi [5];
  int          fail_count = 0;
  int          check_count = 0;
  logic [31:0] rd;

  output_signal_routing #(.PWM_HALF(PH), .OUT_HALF(OH)) uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hall_sel(hall_sel), .enc_count(enc_count),
    .pos_actual(pos_actual), .pwm_out(pwm_out), .dout(dout));

  out_load_model loads (.pclk(pclk), .presetn(presetn), .measure(measure),
    .pwm_out(pwm_out), .dout(dout), .edges(edges), .min_hi(min_hi));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_min(input string what, input int lim, input int got);
    check_count++;
    if (got < lim) begin
      fail_count++;
      $display("MISMATCH %s expected at least %0d seen %0d", what, lim, got);
    end
  endtask

  // apb transfer; waits for pready without assuming its latency
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic err, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
    data = prdata;
    chk_val("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic exp_const(input logic [7:0] src, input logic inv, input logic g);
    return (g ^ inv) && (src == SRC_ONE);
  endfunction

  function automatic int exp_pulses(input logic [7:0] src, input int n);
    if (src <= SRC_ENC_LAST && hall_sel)
      return 0;
    return n >> ((src <= SRC_ENC_LAST) ? src - SRC_ENC_FIRST : src - SRC_POS_FIRST);
  endfunction

  task automatic pulse_run(input int j, input logic [7:0] src, input int n);
    int base;
    int e;
    rw(1'b1, 8'(4 * j), {16'h0, src, 8'h05}, 1'b0, rd);
    repeat (4) @(posedge pclk);
    base = edges[j];
    e = exp_pulses(src, n);
    repeat (n) begin
      @(posedge pclk);
      if (src >= SRC_POS_FIRST)
        pos_actual <= pos_actual + 32'h1;
      else
        enc_count <= enc_count + 32'h1;
    end
    repeat ((e + 2) * 4 * ((j == 0) ? PH : OH) + 10) @(posedge pclk);
    chk_val("pulse count", 32'(e), 32'(edges[j] - base));
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  initial begin
    int n;
    logic [7:0] src;
    logic [6:0] idx;
    logic inv;
    logic [31:0] ocw;
    logic [31:0] mv;
    int j;
    void'($urandom(32'h06C96ED8));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rw(1'b0, 8'(4 * k), 32'h0, 1'b0, rd);
      chk_val("route reset", {16'h0, ROUTE_RESET}, rd);
    end
    rw(1'b0, CTRL_OFS, 32'h0, 1'b0, rd);
    chk_val("ctrl reset", 32'h0, rd);
    rw(1'b0, 8'h30, 32'h0, 1'b1, rd);
    rw(1'b1, STATUS_OFS, 32'hFFFFFFFF, 1'b1, rd);
    $display("test registers done");
    rw(1'b1, CTRL_OFS, 32'h1, 1'b0, rd);
    rw(1'b1, OCW_OFS, 32'h20, 1'b0, rd);
    rw(1'b0, STATUS_OFS, 32'h0, 1'b0, rd);
    chk_val("routing flag", 32'h1, {31'h0, rd[STAT_ROUTING_BIT]});
    measure <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      n = ((2 + $urandom % 3) << k) + $urandom % (1 << k);
      pulse_run(1, SRC_ENC_FIRST + 8'(k), n);
      pulse_run(2, SRC_POS_FIRST + 8'(k), n);
    end
    pulse_run(0, SRC_ENC_FIRST, 5);
    hall_sel <= 1'b1;
    repeat (4) @(posedge pclk);
    pulse_run(3, SRC_ENC_FIRST, 6);
    pulse_run(4, SRC_POS_FIRST, 6);
    hall_sel <= 1'b0;
    measure <= 1'b0;
    chk_min("pwm high time", PH, min_hi[0]);
    for (int k = 1; k < 5; k++)
      chk_min("output high time", OH, min_hi[k]);
    $display("test pulses done");
    rw(1'b1, POL_OFS, 32'hFFFFFFFF, 1'b0, rd);
    rw(1'b1, MAN_EN_OFS, 32'hFFFFFFFF, 1'b0, rd);
    mv = $urandom;
    rw(1'b1, MAN_VAL_OFS, mv, 1'b0, rd);
    for (int t = 0; t < 24; t++) begin
      j   = $urandom % 5;
      src = 8'($urandom % 2);
      idx = 7'($urandom % 32);
      inv = 1'($urandom);
      ocw = $urandom;
      rw(1'b1, 8'(4 * j), {16'h0, src, inv, idx}, 1'b0, rd);
      rw(1'b1, OCW_OFS, ocw, 1'b0, rd);
      repeat (4) @(posedge pclk);
      chk_val("const out", {31'h0, exp_const(src, inv, ocw[idx[4:0]])},
              {31'h0, (j == 0) ? pwm_out : dout[j - 1]});
      rw(1'b0, 8'(4 * j), 32'h0, 1'b0, rd);
      chk_val("route readback", {16'h0, src, inv, idx}, rd);
    end
    $display("test constants done");
    rw(1'b1, 8'h00, {16'h0, SRC_ONE, 8'h05}, 1'b0, rd);
    rw(1'b1, CTRL_OFS, 32'h0, 1'b0, rd);
    repeat (4) @(posedge pclk);
    chk_val("pwm idle", 32'h0, {31'h0, pwm_out});
    rw(1'b0, STATUS_OFS, 32'h0, 1'b0, rd);
    chk_val("routing flag", 32'h0, {31'h0, rd[STAT_ROUTING_BIT]});
    chk_val("legacy manual", {28'h0, mv[19:16]}, {28'h0, dout});
    rw(1'b1, MAN_EN_OFS, 32'h0, 1'b0, rd);
    repeat (4) @(posedge pclk);
    chk_val("legacy polarity", {28'h0, ~ocw[19:16]}, {28'h0, dout});
    $display("test disable done");
    stop_test();
  end
endmodule
